// File: core/tstc_capture.sv
// Trigger timestamp counter, seconds split and capture FIFO
`timescale 1ns/10ps
module tstc_capture (
    input  wire logic        clk,
    input  wire logic        arst_n,
    input  wire logic        sampleEn,
    input  wire logic        stampReset,
    input  wire logic        trigger,
    input  wire logic        refMode,
    input  wire logic        secPulse,
    input  wire logic        overflowClear,
    output logic      [63:0] stampData,
    output logic             stampValid,
    input  wire logic        stampReady,
    output logic             overflow
);
    typedef struct packed {
        logic [63:0] count;
        logic [2:0]  secSync;
        logic        secLevel;
        logic        overflow;
    } tstc_state_type;
    tstc_state_type st;
    tstc_state_type next_st;
    logic pulseRise;
    logic fifoReady;
    logic pushValid;

    // Rising edge once second and third stages agree
    assign pulseRise = (st.secSync[1] == st.secSync[2]) && st.secSync[2] && !st.secLevel;
    assign pushValid = trigger;

    always_comb begin
        next_st = st;
        next_st.secSync = {st.secSync[1:0], secPulse};
        if (st.secSync[1] == st.secSync[2]) begin
            next_st.secLevel = st.secSync[2];
        end
        if (stampReset) begin
            next_st.count = tstc_pkg::COUNT_RESET;
        end else if (refMode) begin
            if (pulseRise) begin
                next_st.count[tstc_pkg::HALF_WIDTH-1:0] = tstc_pkg::HALF_RESET;
                next_st.count[tstc_pkg::STAMP_WIDTH-1:tstc_pkg::HALF_WIDTH] =
                    st.count[tstc_pkg::STAMP_WIDTH-1:tstc_pkg::HALF_WIDTH]
                    + tstc_pkg::HALF_STEP;
            end else if (sampleEn) begin
                next_st.count[tstc_pkg::HALF_WIDTH-1:0] =
                    st.count[tstc_pkg::HALF_WIDTH-1:0] + tstc_pkg::HALF_STEP;
            end
        end else if (sampleEn) begin
            next_st.count = st.count + tstc_pkg::COUNT_STEP;
        end
        if (pushValid && !fifoReady) begin
            next_st.overflow = 1'b1;
        end else if (overflowClear) begin
            next_st.overflow = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st.count    <= tstc_pkg::COUNT_RESET;
            st.secSync  <= tstc_pkg::SYNC_RESET;
            st.secLevel <= 1'b0;
            st.overflow <= 1'b0;
        end else begin
            st <= next_st;
        end
    end

    // Capture path never waits for the reader; triggers are dropped while the FIFO is full
    tstc_fifo #(
        .WIDTH (tstc_pkg::STAMP_WIDTH),
        .DEPTH (tstc_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk      (clk),
        .arst_n   (arst_n),
        .inData   (st.count),
        .inValid  (pushValid),
        .inReady  (fifoReady),
        .outData  (stampData),
        .outValid (stampValid),
        .outReady (stampReady)
    );

    assign overflow = st.overflow;

    property p_reset_clears;
        @(posedge clk) disable iff (!arst_n) stampReset |=> st.count == 64'h0;
    endproperty
    a_reset_clears: assert property (p_reset_clears) else $error("count not cleared");

    property p_count_step;
        @(posedge clk) disable iff (!arst_n)
            (!stampReset && !refMode && sampleEn) |=> st.count == $past(st.count) + 64'h1;
    endproperty
    a_count_step: assert property (p_count_step) else $error("count did not step");

    property p_count_hold;
        @(posedge clk) disable iff (!arst_n)
            (!stampReset && !refMode && !sampleEn) |=> $stable(st.count);
    endproperty
    a_count_hold: assert property (p_count_hold) else $error("count moved");

    property p_capture;
        @(posedge clk) disable iff (!arst_n)
            (trigger && fifoReady && !stampValid) |=> stampValid && stampData == $past(st.count);
    endproperty
    a_capture: assert property (p_capture) else $error("capture lost");

    property p_no_stall;
        @(posedge clk) disable iff (!arst_n)
            (!stampReady && !stampReset && !refMode && sampleEn) |=> st.count != $past(st.count);
    endproperty
    a_no_stall: assert property (p_no_stall) else $error("count stalled");

    property p_sec_step;
        @(posedge clk) disable iff (!arst_n)
            (refMode && !stampReset && pulseRise) |=>
                st.count[63:32] == $past(st.count[63:32]) + 32'h1;
    endproperty
    a_sec_step: assert property (p_sec_step) else $error("seconds not counted");

    property p_sub_clear;
        @(posedge clk) disable iff (!arst_n)
            (refMode && !stampReset && pulseRise) |=> st.count[31:0] == 32'h0;
    endproperty
    a_sub_clear: assert property (p_sub_clear) else $error("subsecond not cleared");

    property p_split_hold;
        @(posedge clk) disable iff (!arst_n)
            (refMode && !stampReset && !pulseRise) |=> $stable(st.count[63:32]);
    endproperty
    a_split_hold: assert property (p_split_hold) else $error("seconds moved");

    sequence s_drop;
        trigger && !fifoReady;
    endsequence

    sequence s_flag_held;
        overflow ##1 (overflow || $past(overflowClear));
    endsequence

    sequence s_split_edge;
        refMode && !stampReset && pulseRise;
    endsequence

    property p_overflow;
        @(posedge clk) disable iff (!arst_n)
            s_drop |=> s_flag_held;
    endproperty
    a_overflow: assert property (p_overflow) else $error("overflow not sticky");

    property p_set_wins;
        @(posedge clk) disable iff (!arst_n)
            (trigger && !fifoReady && overflowClear) |=> overflow;
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("clear beat overflow set");

    property p_overflow_sticky;
        @(posedge clk) disable iff (!arst_n)
            (overflow && !overflowClear) |=> overflow;
    endproperty
    a_overflow_sticky: assert property (p_overflow_sticky) else $error("overflow lost");

    property p_overflow_clear;
        @(posedge clk) disable iff (!arst_n)
            (overflowClear && !(trigger && !fifoReady)) |=> !overflow;
    endproperty
    a_overflow_clear: assert property (p_overflow_clear) else $error("overflow kept");

    property p_drop_keeps;
        @(posedge clk) disable iff (!arst_n)
            (trigger && !fifoReady && !stampReady) |=> !fifoReady;
    endproperty
    a_drop_keeps: assert property (p_drop_keeps) else $error("full FIFO changed");

    property p_pop_frees;
        @(posedge clk) disable iff (!arst_n)
            (stampValid && stampReady && !trigger) |=> fifoReady;
    endproperty
    a_pop_frees: assert property (p_pop_frees) else $error("pop left FIFO full");

    property p_empty_hold;
        @(posedge clk) disable iff (!arst_n)
            (!stampValid && !trigger) |=> !stampValid;
    endproperty
    a_empty_hold: assert property (p_empty_hold) else $error("word without trigger");

    property p_push_valid;
        @(posedge clk) disable iff (!arst_n)
            (trigger && fifoReady) |=> stampValid;
    endproperty
    a_push_valid: assert property (p_push_valid) else $error("push not visible");

    property p_rise_once;
        @(posedge clk) disable iff (!arst_n)
            pulseRise |=> !pulseRise;
    endproperty
    a_rise_once: assert property (p_rise_once) else $error("pulse counted twice");

    property p_sub_step;
        @(posedge clk) disable iff (!arst_n)
            (refMode && !stampReset && !pulseRise && sampleEn) |=>
                st.count[31:0] == $past(st.count[31:0]) + 32'h1;
    endproperty
    a_sub_step: assert property (p_sub_step) else $error("subsecond did not step");

    property p_sub_hold;
        @(posedge clk) disable iff (!arst_n)
            (refMode && !stampReset && !pulseRise && !sampleEn) |=> $stable(st.count[31:0]);
    endproperty
    a_sub_hold: assert property (p_sub_hold) else $error("subsecond moved");

    property p_sub_restart;
        @(posedge clk) disable iff (!arst_n)
            s_split_edge ##1 (refMode && !stampReset && !pulseRise) |=>
                st.count[31:0] == {31'h0, $past(sampleEn)};
    endproperty
    a_sub_restart: assert property (p_sub_restart) else $error("subsecond restart wrong");
endmodule : tstc_capture

// File: core/tstc_pkg.sv
// Package with constants for the trigger timestamp capture block
package tstc_pkg;
    localparam int STAMP_WIDTH = 64;
    localparam int HALF_WIDTH  = 32;
    localparam int FIFO_DEPTH  = 16;
    localparam logic [63:0] COUNT_RESET = 64'h0000_0000_0000_0000;
    localparam logic [31:0] HALF_RESET  = 32'h0000_0000;
    localparam logic [63:0] COUNT_STEP  = 64'h0000_0000_0000_0001;
    localparam logic [31:0] HALF_STEP   = 32'h0000_0001;
    localparam logic [2:0]  SYNC_RESET  = 3'h0;
endpackage : tstc_pkg

// File: core/tstc_fifo.sv
// Parameterised FIFO with valid and ready on both sides
`timescale 1ns/10ps
module tstc_fifo #(
    parameter int WIDTH = 64,
    parameter int DEPTH = 16
) (
    input  wire logic             clk,
    input  wire logic             arst_n,
    input  wire logic [WIDTH-1:0] inData,
    input  wire logic             inValid,
    output logic                  inReady,
    output logic      [WIDTH-1:0] outData,
    output logic                  outValid,
    input  wire logic             outReady
);
    localparam int AW = $clog2(DEPTH);
    typedef struct packed {
        logic [AW-1:0] wrPtr;
        logic [AW-1:0] rdPtr;
        logic [AW:0]   count;
    } tstc_fifo_state_type;
    tstc_fifo_state_type st;
    tstc_fifo_state_type next_st;
    logic [WIDTH-1:0] mem [DEPTH];
    logic             doWrite;
    logic             doRead;

    assign inReady  = (st.count != (AW+1)'(DEPTH));
    assign outValid = (st.count != '0);
    assign doWrite  = inValid && inReady;
    assign doRead   = outValid && outReady;
    assign outData  = mem[st.rdPtr];

    always_comb begin
        next_st = st;
        if (doWrite) begin
            next_st.wrPtr = st.wrPtr + AW'(1);
        end
        if (doRead) begin
            next_st.rdPtr = st.rdPtr + AW'(1);
        end
        next_st.count = st.count + (AW+1)'(doWrite) - (AW+1)'(doRead);
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    always_ff @(posedge clk) begin
        if (doWrite) begin
            mem[st.wrPtr] <= inData;
        end
    end
endmodule : tstc_fifo

// File: test/tstc_host_model.sv
// Host side model that pops timestamps with random stalls
`timescale 1ns/10ps
module tstc_host_model (
    input  wire logic clk,
    input  wire logic stall,
    output logic      stampReady
);
    initial stampReady = 1'b0;
    // Reads at its own pace, unrelated to sampling
    always @(negedge clk) begin
        stampReady <= !stall && ($urandom_range(3) != 0);
    end
endmodule : tstc_host_model

// File: test/trigger_timestamp_capture_test.sv
// Self-checking testbench for the trigger timestamp capture block
`timescale 1ns/10ps
module trigger_timestamp_capture_test;
    logic        clk = 0, arst_n = 0, sampleEn = 0, stampReset = 0, trigger = 0;
    logic        refMode = 0, secPulse = 0, overflowClear = 0, stall = 1, modelOn = 0;
    logic        stampReady, stampValid, overflow;
    logic [63:0] stampData, cnt = 0, want = 0;
    logic [63:0] q[$];
    int          num_errors = 0, cmp_count = 0, occ = 0, cycles = 0;

    always #12.5 clk = ~clk;

    tstc_capture u_dut (.clk(clk), .arst_n(arst_n), .sampleEn(sampleEn),
        .stampReset(stampReset), .trigger(trigger), .refMode(refMode),
        .secPulse(secPulse), .overflowClear(overflowClear), .stampData(stampData),
        .stampValid(stampValid), .stampReady(stampReady), .overflow(overflow));
    tstc_host_model u_host (.clk(clk), .stall(stall), .stampReady(stampReady));

    task check(input string name, input logic [63:0] seen, input logic [63:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    function automatic logic [63:0] expect_count(input logic [63:0] prev, input logic clr,
                                                 input logic step);
        return clr ? 64'h0 : prev + 64'(step);
    endfunction : expect_count

    function automatic logic [63:0] expect_split(input int secs, input int subs);
        return {secs[31:0], subs[31:0]};
    endfunction : expect_split

    task results;
        if (num_errors == 0 && cmp_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : results

    task cyc(input int n);
        repeat (n) @(negedge clk);
    endtask : cyc

    // Reference counter and expected FIFO contents
    always @(posedge clk) begin
        cycles++;
        if (cycles > 20000) begin
            num_errors++;
            results();
        end
        if (modelOn && trigger && occ < 16) begin
            q.push_back(cnt);
            occ++;
        end
        if (stampValid === 1'b1 && stampReady === 1'b1) begin
            check("popAllowed", 64'(q.size() != 0), 64'h1);
            if (q.size() != 0) want = q.pop_front();
            check("stampData", stampData, want);
            occ--;
        end
        if (modelOn) cnt <= expect_count(cnt, stampReset, sampleEn);
    end

    initial begin
        void'($urandom(32'hB955557F));
        cyc(20);
        check("overflow", overflow, 64'h0);
        check("stampValid", stampValid, 64'h0);
        arst_n = 1;
        modelOn = 1;
        stall <= 0;
        repeat (3000) begin
            sampleEn = 1'($urandom_range(1));
            trigger = ($urandom_range(7) == 0);
            stampReset = ($urandom_range(199) == 0);
            cyc(1);
        end
        sampleEn = 0;
        trigger = 0;
        stampReset = 0;
        cyc(40);
        stall <= 1;
        trigger = 1;
        cyc(20);
        trigger = 0;
        cyc(2);
        check("overflow", overflow, 64'h1);
        check("stampValid", stampValid, 64'h1);
        trigger = 1;
        overflowClear = 1;
        cyc(1);
        trigger = 0;
        overflowClear = 0;
        cyc(1);
        check("overflow", overflow, 64'h1);
        stall <= 0;
        cyc(60);
        check("stampValid", stampValid, 64'h0);
        check("overflow", overflow, 64'h1);
        overflowClear = 1;
        cyc(1);
        overflowClear = 0;
        cyc(1);
        check("overflow", overflow, 64'h0);
        modelOn = 0;
        stampReset = 1;
        cyc(1);
        stampReset = 0;
        refMode = 1;
        for (int k = 1; k < 4; k++) begin
            if (k == 3) begin
                stampReset = 1;
                cyc(1);
                stampReset = 0;
            end
            secPulse = 1;
            cyc(8);
            secPulse = 0;
            for (int n = 0; n < 2; n++) begin
                q.push_back(expect_split((k == 3) ? 1 : k, n * 5));
                occ++;
                trigger = 1;
                cyc(1);
                trigger = 0;
                repeat (5) begin
                    sampleEn = 1;
                    cyc(1);
                    sampleEn = 0;
                    cyc(1);
                end
            end
        end
        cyc(20);
        check("queue", 64'(occ), 64'h0);
        check("stampValid", stampValid, 64'h0);
        results();
    end
endmodule : trigger_timestamp_capture_test
